// ===== ddr2_mode_register_config.sv
// load-config decode, persistent config state and latency timing
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_cfg_params.svh"

// How it works
// [R01] test bit set: enter test mode, leave other main fields unchanged
// [R02] dll reset bit starts a reset and is not stored, so reads zero
// [R03] controller waits 200 clocks after a dll reset before any read
// [R04] write with auto precharge: precharge pulse write-recovery clocks after burst end
// [R05] controller programs write recovery 2..7 from time over period, rounded up
// [R06] power-down select zero: fast exit, dll kept running
// [R07] power-down select one: slow exit, dll frozen in active power-down
// [R08] latency field selects 3 to 7 whole clocks
// [R09] with zero additive latency data starts at read edge plus latency
// [R10] controller loads only when idle and waits before next command
// [R11] config persists until reprogrammed; array untouched
// [R12] controller keeps dll enabled and follows enabling with a dll reset
// [R13] self refresh freezes dll; exit re-enables and resets, 200 clock wait
// [R14] drive bit zero full strength, one reduced strength
// [R15] complement strobe disable bit one makes strobe single-ended
// [R16] redundant complement only when redundant bit one and complement enabled
// [R17] output disable bit turns off all data and strobe outputs
// [R18] two bits select termination 50, 75, 150 ohms or off
// [R19] termination input honoured only in active and power-down states
// [R20] controller keeps termination low eight clocks after enabling it
// [R21] bank bits all zero load the main register
// [R22] bank bit0 high, bit1 low loads the extended register; code also needs bank bit2 low
// [R23] read latency is additive plus column latency
// [R24] reserved latency, recovery or additive latency codes flag bad configuration
module ddr2_mode_register_config
    import ddr2_cfg_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,

    // command from the controller pins
    input  wire ddr2_cfg_pkg::cmd_s      cmd_in,
    input  wire logic                    burst_last,
    input  wire logic                    odt_pin,
    input  wire logic                    active_pd,

    // decoded configuration
    output ddr2_cfg_pkg::cfg_s           cfg,

    // dll and power-down status
    output logic                         dll_running,
    output logic                         dll_reset_pulse,
    output logic                         dll_locking,
    output logic                         pd_fast_exit,

    // data path controls
    output logic                         read_data_start,
    output logic                         auto_precharge,
    output logic                         termination_on,
    output logic                         odt_hold_active,
    output logic                         dq_out_en,
    output logic                         strobe_out_en,
    output logic                         strobe_n_out_en
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [`CMD_W+`BANK_W+`CODE_W+2:0] sync1_r;
    logic [`CMD_W+`BANK_W+`CODE_W+2:0] sync2_r;
    // both stages clear so no stale command fires
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {cmd_in, burst_last, odt_pin, active_pd};
            sync2_r <= sync1_r;
        end
    end

    // synchronised view of the pins
    cmd_s c;
    logic burst_last_s;
    logic odt_s;
    logic active_pd_s;
    assign c            = sync2_r[`CMD_W+`BANK_W+`CODE_W+2:3];
    assign burst_last_s = sync2_r[2];
    assign odt_s        = sync2_r[1];
    assign active_pd_s  = sync2_r[0];

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [13:0] main_reg;
        logic [13:0] ext_reg;
        logic        test_mode;
        logic        self_refresh;
        // dll_rst and odt_load are one-cycle strobes
        logic        dll_rst;
        logic        wr_pending;
        logic        odt_load;
    } st_s;

    st_s st_r;
    st_s st_nxt;

    // decode strobes and wait status
    logic load_main;
    logic load_ext;
    logic lock_busy;
    logic odt_busy;

    logic rd_fire;
    logic wr_fire;

    logic rtt_new_on;
    // at most 14, so four bits suffice
    logic [3:0] rl;

    // decode sees the pins two cycles late
    // [R21] main register select
    assign load_main = (c.cmd == `CMD_LOAD) && (c.bank == `BANK_MAIN);
    // [R22] extended register select
    assign load_ext  = (c.cmd == `CMD_LOAD) && (c.bank == `BANK_EXT1);

    assign rtt_new_on = {c.code[`EXT_RTT_HI_BIT], c.code[`EXT_RTT_LO_BIT]} != 2'b00;

    // next state of the decode
    always_comb begin
        st_nxt = st_r;
        st_nxt.dll_rst = 1'b0;
        st_nxt.odt_load = 1'b0;

        if (load_main) begin
            // [R01] test mode keeps other fields
            if (c.code[`MAIN_TEST_BIT]) begin
                st_nxt.test_mode = 1'b1;
            end else begin
                // [R11] hold until reprogrammed
                st_nxt.test_mode = 1'b0;
                st_nxt.main_reg = c.code;

                // [R02] self-clearing reset bit
                st_nxt.main_reg[`MAIN_DLLRST_BIT] = 1'b0;
                st_nxt.dll_rst = c.code[`MAIN_DLLRST_BIT];
            end
        end

        // extended register load
        if (load_ext) begin
            st_nxt.ext_reg = c.code;
            st_nxt.odt_load = rtt_new_on;
        end

        // [R13] dll off in self refresh, reset on exit
        if (c.cmd == `CMD_SR_ENTER) begin
            st_nxt.self_refresh = 1'b1;
        end else if (c.cmd == `CMD_SR_EXIT && st_r.self_refresh) begin
            st_nxt.self_refresh = 1'b0;
            st_nxt.dll_rst = 1'b1;
        end

        // set by the command, consumed by the burst end
        if (c.cmd == `CMD_WRITE_AP) begin
            st_nxt.wr_pending = 1'b1;
        end else if (burst_last_s) begin
            st_nxt.wr_pending = 1'b0;
        end
    end

    // next state is built above; this only registers it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '{main_reg: `MAIN_RESET, ext_reg: `EXT_RESET, default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // waits
    // ----------------------------------------
    // lock wait is only reported; reads are not held off
    // [R03] lock window shown for the controller
    ddr2_cfg_counter u_lock (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load     (st_r.dll_rst),
        .load_val (8'(`DLL_LOCK_CYCLES)),
        .busy     (lock_busy)
    );

    // starts from the registered load strobe
    // [R20] termination hold window after enabling
    ddr2_cfg_counter u_odt (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load     (st_r.odt_load),
        .load_val (8'(`ODT_HOLD_CYCLES)),
        .busy     (odt_busy)
    );

    // [R23] read latency sum
    assign rl = {1'b0, st_r.main_reg[`MAIN_CL_LO +: 3]} + {1'b0, st_r.ext_reg[`EXT_AL_LO +: 3]};

    // one read tracked; a new read restarts it
    // [R09] read data start at n plus latency
    ddr2_cfg_delay u_rd (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (c.cmd == `CMD_READ),
        .delay   (rl),
        .fire    (rd_fire)
    );

    // a write without a later burst end never fires
    // [R04] precharge after write recovery
    ddr2_cfg_delay u_wr (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (st_r.wr_pending && burst_last_s),
        .delay   ({1'b0, st_r.main_reg[`MAIN_WR_LO +: 3]}),
        .fire    (wr_fire)
    );

    // ----------------------------------------
    // decoded outputs
    // ----------------------------------------
    // field views of the stored registers
    logic [2:0] cl_f;
    logic [2:0] wr_f;
    logic [2:0] al_f;
    logic       strb_n_dis;
    logic       qoff;

    assign cl_f = st_r.main_reg[`MAIN_CL_LO +: 3];
    assign wr_f = st_r.main_reg[`MAIN_WR_LO +: 3];
    assign al_f = st_r.ext_reg[`EXT_AL_LO +: 3];
    assign strb_n_dis = st_r.ext_reg[`EXT_STRB_N_BIT];
    assign qoff = st_r.ext_reg[`EXT_QOFF_BIT];

    always_comb begin
        // stored fields
        cfg.test_mode = st_r.test_mode;

        // [R08] whole-clock latency field
        cfg.read_latency_field = cl_f;
        // additive part is folded in before the delay
        cfg.total_read_latency = rl;

        cfg.write_recovery_field = wr_f;

        cfg.active_powerdown_exit_select = st_r.main_reg[`MAIN_PD_BIT];

        cfg.dll_enable_bit = st_r.ext_reg[`EXT_DLL_BIT];

        // [R14] drive strength select
        cfg.drive_strength_bit = st_r.ext_reg[`EXT_DRV_BIT];

        // [R15] complement strobe enable
        cfg.strobe_n_en = !strb_n_dis;

        cfg.redundant_strobe_en = st_r.ext_reg[`EXT_RSTRB_BIT];

        // [R16] redundant complement gate
        cfg.redundant_strobe_n_en = st_r.ext_reg[`EXT_RSTRB_BIT] && !strb_n_dis;

        cfg.output_disable_bit = qoff;

        // [R18] termination select
        cfg.termination_resistance = rtt_e'({st_r.ext_reg[`EXT_RTT_HI_BIT], st_r.ext_reg[`EXT_RTT_LO_BIT]});

        // [R24] reserved encodings flagged
        cfg.bad_config = (cl_f < `CL_MIN) || (wr_f < `WR_MIN) || (al_f > `AL_MAX);
    end


    // dll is enabled by the register but is held off in self refresh
    // select only matters while active_pd is high
    // [R06] fast exit keeps dll running
    // [R07] slow exit freezes dll in active power-down
    assign pd_fast_exit    = !st_r.main_reg[`MAIN_PD_BIT];
    assign dll_running     = st_r.ext_reg[`EXT_DLL_BIT] && !st_r.self_refresh
                             && !(active_pd_s && st_r.main_reg[`MAIN_PD_BIT]);

    assign dll_reset_pulse = st_r.dll_rst;
    assign dll_locking     = lock_busy;

    assign read_data_start = rd_fire;
    assign auto_precharge  = wr_fire;

    assign odt_hold_active = odt_busy;

    // [R19] termination ignored in self refresh
    assign termination_on  = odt_s && !st_r.self_refresh
                             && (cfg.termination_resistance != RTT_OFF);

    // data and strobe enables from the extended register
    // [R17] output disable
    assign dq_out_en       = !qoff;
    assign strobe_out_en   = !qoff;
    assign strobe_n_out_en = !qoff && !strb_n_dis;
endmodule
`default_nettype wire

// ===== ddr2_cfg_params.svh
// constants for the load-config decode block
`ifndef DDR2_CFG_PARAMS_SVH
`define DDR2_CFG_PARAMS_SVH

// ----------------------------------------
// command and bank select
// ----------------------------------------
`define CMD_W            3
`define BANK_W           3
`define CODE_W           14
`define BANK_MAIN        3'h0
`define BANK_EXT1        3'h1
`define CMD_NOP          3'h0
`define CMD_LOAD         3'h1
`define CMD_READ         3'h2
`define CMD_WRITE_AP     3'h3
`define CMD_SR_ENTER     3'h4
`define CMD_SR_EXIT      3'h5

// ----------------------------------------
// main register fields
// ----------------------------------------
`define MAIN_CL_LO       4
`define MAIN_TEST_BIT    7
`define MAIN_DLLRST_BIT  8
`define MAIN_WR_LO       9
`define MAIN_PD_BIT      12

// ----------------------------------------
// extended register fields
// ----------------------------------------
`define EXT_DLL_BIT      0
`define EXT_DRV_BIT      1
`define EXT_RTT_LO_BIT   2
`define EXT_AL_LO        3
`define EXT_RTT_HI_BIT   6
`define EXT_STRB_N_BIT   10
`define EXT_RSTRB_BIT    11
`define EXT_QOFF_BIT     12

// ----------------------------------------
// field limits and reset values
// ----------------------------------------
`define CL_MIN           3'h3
`define CL_MAX           3'h7
`define WR_MIN           3'h2
`define WR_MAX           3'h7
`define AL_MAX           3'h6
`define MAIN_RESET       14'h0000
`define EXT_RESET        14'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS    10
`define DLL_LOCK_CYCLES  200
`define ODT_HOLD_CYCLES  8
`define CNT_W            8
`define LAT_W            4

`endif

// ===== ddr2_cfg_pkg.sv
// types shared by the load-config decode block
package ddr2_cfg_pkg;

    typedef enum logic [1:0] {
        RTT_OFF = 2'b00,
        RTT_75  = 2'b01,
        RTT_150 = 2'b10,
        RTT_50  = 2'b11
    } rtt_e;

    typedef struct packed {
        logic [2:0]  cmd;
        logic [2:0]  bank;
        logic [13:0] code;
    } cmd_s;

    typedef struct packed {
        logic       test_mode;
        logic [2:0] read_latency_field;
        logic [3:0] total_read_latency;
        logic [2:0] write_recovery_field;
        logic       active_powerdown_exit_select;
        logic       dll_enable_bit;
        logic       drive_strength_bit;
        logic       strobe_n_en;
        logic       redundant_strobe_en;
        logic       redundant_strobe_n_en;
        logic       output_disable_bit;
        rtt_e       termination_resistance;
        logic       bad_config;
    } cfg_s;

endpackage

// ===== ddr2_cfg_counter.sv
// down counter that reports when a wait has elapsed
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_cfg_params.svh"
module ddr2_cfg_counter (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // control
    input  wire logic                load,
    input  wire logic [`CNT_W-1:0]   load_val,
    // status
    output logic                     busy
);
    typedef struct packed {
        logic [`CNT_W-1:0] cnt;
    } st_s;
    st_s st_r;
    st_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.cnt = load_val;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = (st_r.cnt != '0);
endmodule
`default_nettype wire

// ===== ddr2_cfg_delay.sv
// countdown that fires a pulse a programmed number of cycles later
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_cfg_params.svh"
module ddr2_cfg_delay (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // start
    input  wire logic                start,
    input  wire logic [`LAT_W-1:0]   delay,
    // result
    output logic                     fire
);
    typedef struct packed {
        logic [`LAT_W-1:0] cnt;
        logic              run;
        logic              fire;
    } st_s;
    st_s st_r;
    st_s st_nxt;

    // a new start restarts the wait; only one event is tracked at a time
    always_comb begin
        st_nxt = st_r;
        st_nxt.fire = 1'b0;
        if (start) begin
            st_nxt.run = (delay > 4'h1);
            st_nxt.fire = (delay <= 4'h1);
            st_nxt.cnt = delay - 4'h1;
        end else if (st_r.run) begin
            if (st_r.cnt <= 4'h1) begin
                st_nxt.run = 1'b0;
                st_nxt.fire = 1'b1;
            end
            st_nxt.cnt = st_r.cnt - 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fire = st_r.fire;
endmodule
`default_nettype wire

// ===== ddr2_mode_register_config_properties.sv
// concurrent checks on the load-config decode block
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_cfg_params.svh"
module ddr2_mode_register_config_properties
    import ddr2_cfg_pkg::*;
(
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               rst,
    // pins
    input wire ddr2_cfg_pkg::cmd_s cmd_in,
    input wire logic               burst_last,
    // outputs
    input wire ddr2_cfg_pkg::cfg_s cfg,
    input wire logic               dll_reset_pulse,
    input wire logic               dll_locking,
    input wire logic               pd_fast_exit,
    input wire logic               read_data_start,
    input wire logic               auto_precharge,
    input wire logic               termination_on,
    input wire logic               dq_out_en,
    input wire logic               strobe_n_out_en
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ----
    // cycles since read, burst end and dll reset
    // ----
    // counts saturate so a long idle stretch cannot wrap into a match
    logic [7:0] rd_n;
    logic [7:0] wr_n;
    logic [7:0] lk_n;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_n <= 8'hFF;
            wr_n <= 8'hFF;
            lk_n <= 8'h00;
        end else begin
            rd_n <= (cmd_in.cmd == `CMD_READ) ? 8'h01 : rd_n + 8'(rd_n != 8'hFF);
            wr_n <= burst_last ? 8'h01 : wr_n + 8'(wr_n != 8'hFF);
            lk_n <= dll_reset_pulse ? 8'h01 : lk_n + 8'(lk_n != 8'h00 && lk_n != 8'hFF);
        end
    end
    sequence s_main_load;
        cmd_in.cmd == `CMD_LOAD && cmd_in.bank == `BANK_MAIN;
    endsequence
    sequence s_ext_load;
        cmd_in.cmd == `CMD_LOAD && cmd_in.bank == `BANK_EXT1;
    endsequence
    // ----
    // properties
    // ----
    a_dll_reset_pulse: assert property (
        s_main_load ##0 (cmd_in.code[8] && !cmd_in.code[7]) |-> ##3 dll_reset_pulse ##1 !dll_reset_pulse)
        else $error("dll reset pulse missing");
    a_dll_lock_window: assert property (
        !dll_reset_pulse |-> dll_locking == (lk_n >= 8'h01 && lk_n <= 8'hC8))
        else $error("dll lock window wrong");
    a_test_mode_hold: assert property (
        s_main_load ##0 cmd_in.code[7] |-> ##4 cfg.test_mode
        && cfg.read_latency_field == $past(cfg.read_latency_field, 4)) else $error("test mode load wrong");
    a_main_fields: assert property (
        s_main_load ##0 !cmd_in.code[7] |-> ##4 cfg.read_latency_field == $past(cmd_in.code[6:4], 4)
        && cfg.write_recovery_field == $past(cmd_in.code[11:9], 4)) else $error("main fields wrong");
    a_ext_fields: assert property (
        s_ext_load |-> ##4 cfg.drive_strength_bit == $past(cmd_in.code[1], 4)
        && cfg.dll_enable_bit == $past(cmd_in.code[0], 4)
        && cfg.termination_resistance == $past({cmd_in.code[6], cmd_in.code[2]}, 4))
        else $error("extended fields wrong");
    a_read_latency: assert property (
        read_data_start |-> rd_n == 8'(cfg.total_read_latency) + 8'h02) else $error("read latency wrong");
    a_write_recovery: assert property (
        auto_precharge |-> wr_n == 8'(cfg.write_recovery_field) + 8'h02) else $error("precharge delay wrong");
    a_strobe_enables: assert property (
        dq_out_en == !cfg.output_disable_bit && strobe_n_out_en == (!cfg.output_disable_bit && cfg.strobe_n_en)
        && cfg.redundant_strobe_n_en == (cfg.redundant_strobe_en && cfg.strobe_n_en)) else $error("strobe enables");
    a_fast_exit_sel: assert property (
        pd_fast_exit == !cfg.active_powerdown_exit_select) else $error("exit select wrong");
    a_term_gate: assert property (
        termination_on |-> cfg.termination_resistance != RTT_OFF) else $error("termination while off");
endmodule
`default_nettype wire

// ===== ddr2_cfg_ctrl_model.sv
// controller-side model driving commands and pins into the decode block
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_cfg_params.svh"
module ddr2_cfg_ctrl_model
    import ddr2_cfg_pkg::*;
(
    // clock
    input  wire logic          clk_sys,
    // pins toward the device
    output ddr2_cfg_pkg::cmd_s cmd_in,
    output logic               burst_last,
    output logic               odt_pin,
    output logic               active_pd
);
    int cyc = 0;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
    end
    initial begin
        cmd_in = '0;
        burst_last = 1'b0;
        odt_pin = 1'b0;
        active_pd = 1'b0;
    end
    // ----
    // command issue
    // ----
    // idle gap before each command
    task automatic send(input logic [2:0] c, input logic [2:0] b, input logic [13:0] d, output int k);
        repeat (6) @(posedge clk_sys);
        #1;
        // termination low at loads and refresh entry
        if (c == `CMD_LOAD || c == `CMD_SR_ENTER) begin
            odt_pin = 1'b0;
        end
        cmd_in = '{c, b, d};
        k = cyc + 1;
        @(posedge clk_sys);
        #1;
        // released lines show the inverse, never the old value
        cmd_in = '{`CMD_NOP, ~b, ~d};
    endtask
    // eight clocks low before raising termination
    task automatic pins(input logic o, input logic a);
        repeat (8) @(posedge clk_sys);
        #1;
        odt_pin = o;
        active_pd = a;
    endtask
    task automatic burst(output int j);
        @(posedge clk_sys);
        #1;
        burst_last = 1'b1;
        j = cyc + 1;
        @(posedge clk_sys);
        #1;
        burst_last = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the load-config decode block
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_cfg_params.svh"
module tb
    import ddr2_cfg_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    cmd_s        cmd_in;
    logic        burst_last, odt_pin, active_pd;
    cfg_s        cfg;
    cfg_s        ex;
    logic        dll_running, dll_reset_pulse, dll_locking, pd_fast_exit;
    logic        read_data_start, auto_precharge, termination_on, odt_hold_active;
    logic        dq_out_en, strobe_out_en, strobe_n_out_en;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          k;
    int          j;
    logic [31:0] exp_q[$];
    always #5 clk_sys = ~clk_sys;
    ddr2_mode_register_config u_ddr2_mode_register_config (
        .clk_sys(clk_sys), .rst(rst), .cmd_in(cmd_in), .burst_last(burst_last), .odt_pin(odt_pin),
        .active_pd(active_pd), .cfg(cfg), .dll_running(dll_running), .dll_reset_pulse(dll_reset_pulse),
        .dll_locking(dll_locking), .pd_fast_exit(pd_fast_exit), .read_data_start(read_data_start),
        .auto_precharge(auto_precharge), .termination_on(termination_on), .odt_hold_active(odt_hold_active),
        .dq_out_en(dq_out_en), .strobe_out_en(strobe_out_en), .strobe_n_out_en(strobe_n_out_en));
    ddr2_cfg_ctrl_model u_ddr2_cfg_ctrl_model (
        .clk_sys(clk_sys), .cmd_in(cmd_in), .burst_last(burst_last), .odt_pin(odt_pin), .active_pd(active_pd));
    // ----
    // shared tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic go(input logic [2:0] c, input logic [2:0] b, input logic [13:0] d);
        u_ddr2_cfg_ctrl_model.send(c, b, d, k);
    endtask
    task automatic pins(input logic o, input logic a);
        u_ddr2_cfg_ctrl_model.pins(o, a);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic seen_ev(input logic [7:0] kind);
        logic [31:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFFFFFF;
        check({kind, 24'(u_ddr2_cfg_ctrl_model.cyc + 1)}, e); // event timing
    endtask
    // pulses are judged in order against the oldest note
    always @(posedge clk_sys) begin
        #2;
        if (dll_reset_pulse !== 1'b0) seen_ev(8'h01);
        if (read_data_start !== 1'b0) seen_ev(8'h02);
        if (auto_precharge !== 1'b0) seen_ev(8'h03);
    end
    // ----
    // scenarios
    // ----
    initial begin
        int cl;
        int al;
        int wr;
        int pd;
        logic [13:0] ec;
        void'($urandom(32'hABA4));
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        idle(1);
        ex = '0;
        ex.strobe_n_en = 1'b1;
        ex.bad_config = 1'b1;
        check(cfg, ex); // reset state
        check({dq_out_en, strobe_out_en, strobe_n_out_en}, 3'h7); // outputs on
        go(`CMD_LOAD, `BANK_EXT1, 14'h0001);
        go(`CMD_LOAD, `BANK_MAIN, 14'h0132);
        exp_q.push_back({8'h01, 24'(k + 3)});
        idle(200);
        for (cl = 3; cl <= 7; cl++) begin
            al = $urandom_range(5, 0);
            wr = $urandom_range(7, 2);
            pd = $urandom_range(1, 0);
            ec = 14'($urandom) & 14'h1C47 | 14'h0001 | 14'(al << 3);
            go(`CMD_LOAD, `BANK_EXT1, ec);
            go(`CMD_LOAD, `BANK_MAIN, {1'b0, pd[0], wr[2:0], 2'b00, cl[2:0], 4'h2});
            idle(4);
            check(cfg.read_latency_field, cl); // latency field
            check(cfg.total_read_latency, cl + al); // latency sum
            check(cfg.write_recovery_field, wr); // stored recovery
            check(pd_fast_exit, !pd); // exit select
            check(cfg.drive_strength_bit, ec[1]); // drive
            check(cfg.termination_resistance, {ec[6], ec[2]}); // resistance
            check({dq_out_en, strobe_out_en}, {2{!ec[12]}}); // output disable
            check(strobe_n_out_en, !ec[12] && !ec[10]); // complement strobe
            check(cfg.redundant_strobe_n_en, ec[11] && !ec[10]); // redundant pair
            check(cfg.bad_config, 1'b0); // legal codes
            go(`CMD_READ, 3'h0, 14'($urandom));
            exp_q.push_back({8'h02, 24'(k + 2 + cl + al)});
            idle(14);
            go(`CMD_WRITE_AP, 3'h0, 14'($urandom));
            u_ddr2_cfg_ctrl_model.burst(j);
            exp_q.push_back({8'h03, 24'(j + 2 + wr)});
            pins(1'b1, 1'b1);
            idle(4);
            check(dll_running, !pd); // power-down dll
            check(termination_on, ec[6] || ec[2]); // power-down termination
            pins(1'b0, 1'b0);
        end
        go(`CMD_LOAD, `BANK_MAIN, 14'h00B2);
        idle(4);
        check({cfg.test_mode, cfg.read_latency_field}, 4'hF); // test entry
        go(`CMD_LOAD, 3'h2, 14'h0042);
        go(`CMD_LOAD, 3'h3, 14'h0042);
        idle(4);
        check(cfg.read_latency_field, 3'h7); // bank decode
        go(`CMD_LOAD, `BANK_MAIN, 14'h0012);
        idle(4);
        check({cfg.test_mode, cfg.bad_config}, 2'h1); // reserved codes
        go(`CMD_LOAD, `BANK_MAIN, 14'h0442);
        go(`CMD_LOAD, `BANK_EXT1, 14'h0005);
        idle(4);
        check(odt_hold_active, 1'b1); // hold window open
        pins(1'b1, 1'b0);
        idle(4);
        check({termination_on, odt_hold_active}, 2'h2); // termination on
        go(`CMD_SR_ENTER, 3'h0, 14'h0000);
        // termination raised inside self refresh on purpose
        pins(1'b1, 1'b0);
        idle(4);
        check({dll_running, termination_on}, 2'h0); // self refresh
        go(`CMD_SR_EXIT, 3'h0, 14'h0000);
        exp_q.push_back({8'h01, 24'(k + 3)});
        idle(8);
        check({dll_running, dll_locking, termination_on}, 3'h7); // relock on exit
        idle(200);
        idle(20);
        check(exp_q.size(), 0); // all pulses seen
        complete_run();
    end
    // run takes under a thousand cycles; this leaves wide margin
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end
endmodule
bind ddr2_mode_register_config ddr2_mode_register_config_properties u_props (
    .clk_sys(clk_sys), .rst(rst), .cmd_in(cmd_in), .burst_last(burst_last), .cfg(cfg),
    .dll_reset_pulse(dll_reset_pulse), .dll_locking(dll_locking), .pd_fast_exit(pd_fast_exit),
    .read_data_start(read_data_start), .auto_precharge(auto_precharge), .termination_on(termination_on),
    .dq_out_en(dq_out_en), .strobe_n_out_en(strobe_n_out_en));
`default_nettype wire
